// ---- inc/lldr_cfg.svh ----
`ifndef LLDR_CFG_SVH
`define LLDR_CFG_SVH
// ----------------------------------------------------------------------
// timing
// ----------------------------------------------------------------------
`define LLDR_CLK_MHZ        10
`define LLDR_DLL_LOCK_CK    11'd1024
`define LLDR_CAL_PERIOD_US  100
`define LLDR_CAL_CYCLES     (`LLDR_CAL_PERIOD_US * `LLDR_CLK_MHZ)
// ----------------------------------------------------------------------
// mode register field positions on the address balls
// ----------------------------------------------------------------------
`define LLDR_MODE_CFG_LSB   0
`define LLDR_MODE_BL_LSB    3
`define LLDR_MODE_MUX_BIT   5
`define LLDR_MODE_DLL_BIT   7
`define LLDR_MODE_IMP_BIT   8
`define LLDR_MODE_ODT_BIT   9
// ----------------------------------------------------------------------
// register map (byte addresses) and reset values
// ----------------------------------------------------------------------
`define LLDR_REG_CFG        12'h000
`define LLDR_REG_MODE       12'h004
`define LLDR_REG_STAT       12'h008
`define LLDR_CFG_RST        2'h0
`define LLDR_IMP_NOMINAL    6'h20
`define LLDR_STAT_RL_LSB    4
`define LLDR_STAT_WL_LSB    8
`define LLDR_STAT_IMP_LSB   12
`define LLDR_STAT_ILL_BIT   18
`endif

// ---- inc/lldr_pkg.sv ----
package lldr_pkg;
  typedef enum logic [1:0] {
    LLDR_W36 = 2'h0,
    LLDR_W18 = 2'h1,
    LLDR_W9  = 2'h2
  } lldr_width_type;

  typedef enum logic [1:0] {
    LLDR_PH_IDLE   = 2'h0,
    LLDR_PH_SECOND = 2'h1
  } lldr_phase_type;

  typedef enum logic [1:0] {
    LLDR_DLL_OFF     = 2'h0,
    LLDR_DLL_LOCKING = 2'h1,
    LLDR_DLL_LOCKED  = 2'h3
  } lldr_dll_type;

  typedef enum logic [2:0] {
    LLDR_CMD_NONE  = 3'h0,
    LLDR_CMD_MODE  = 3'h1,
    LLDR_CMD_READ  = 3'h2,
    LLDR_CMD_WRITE = 3'h3,
    LLDR_CMD_REFR  = 3'h4,
    LLDR_CMD_ILL   = 3'h5
  } lldr_cmd_type;

  typedef struct packed {
    logic       odt;
    logic       imp;
    logic       dll;
    logic       mux;
    logic [1:0] bl;
    logic [2:0] cfg;
  } lldr_mode_type;
endpackage

// ---- inc/lldr_beat_if.sv ----
`timescale 1ns/10ps
interface lldr_beat_if #(parameter int DW = 36);
  logic          rise;
  logic          fall;
  logic          start;
  logic          pre;
  logic [3:0]    beats;
  logic [DW-1:0] base;
  logic [DW-1:0] dq;
  logic          oe;
  logic          valid;
  logic          strobe;
  modport src (output rise, fall, start, pre, beats, base,
               input  dq, oe, valid, strobe);
  modport eng (input  rise, fall, start, pre, beats, base,
               output dq, oe, valid, strobe);
endinterface

// ---- logic/lldr_beat.sv ----
`timescale 1ns/10ps
module lldr_beat #(
  parameter int DW = 36
) (
  input wire logic pclk,
  input wire logic presetn,
  lldr_beat_if.eng bus
);
  logic [3:0]    rem, next_rem;
  logic [3:0]    idx, next_idx;
  logic [DW-1:0] base, next_base;
  logic [DW-1:0] dq, next_dq;
  logic          oe, next_oe;
  logic          valid, next_valid;
  logic          strobe, next_strobe;
  logic          any_edge;
  logic          last;

  // ----------------------------------------------------------------------
  // one data beat per input clock edge, both edges
  // ----------------------------------------------------------------------
  always_comb begin
    any_edge    = bus.rise | bus.fall;
    last        = 1'b0;
    next_rem    = rem;
    next_idx    = idx;
    next_base   = base;
    next_dq     = dq;
    next_oe     = oe;
    next_strobe = strobe;
    // strobe follows the input clock, free running
    if (bus.rise) next_strobe = 1'b1;
    if (bus.fall) next_strobe = 1'b0;
    if (bus.rise && bus.start) begin
      // a new burst may start right after the last one: seamless
      next_base = bus.base;
      next_dq   = bus.base;
      next_oe   = 1'b1;
      next_rem  = bus.beats - 4'h1;
      next_idx  = 4'h1;
    end else if (any_edge && rem != 4'h0) begin
      next_dq  = base + DW'(idx);
      next_rem = rem - 4'h1;
      next_idx = idx + 4'h1;
      last     = (rem == 4'h1);
    end else if (any_edge) begin
      next_oe = 1'b0;
    end
    // pre wins over last so back-to-back bursts keep the flag high
    if (bus.fall && bus.pre) next_valid = 1'b1;
    else if (last)           next_valid = 1'b0;
    else                     next_valid = valid;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem    <= 4'h0;
      idx    <= 4'h0;
      base   <= '0;
      dq     <= '0;
      oe     <= 1'b0;
      valid  <= 1'b0;
      strobe <= 1'b0;
    end else begin
      rem    <= next_rem;
      idx    <= next_idx;
      base   <= next_base;
      dq     <= next_dq;
      oe     <= next_oe;
      valid  <= next_valid;
      strobe <= next_strobe;
    end
  end

  assign bus.dq     = dq;
  assign bus.oe     = oe;
  assign bus.valid  = valid;
  assign bus.strobe = strobe;
endmodule

// ---- logic/lldr_core.sv ----
`timescale 1ns/10ps
`include "lldr_cfg.svh"
// Overview of operation
// - DLL stays disabled after reset until a mode set turns it on.
// - External impedance mode samples the reference resistor periodically, transparently.
// - Internal mode uses nominal 50 ohm code, still recalibrated periodically.
// - Multiplexed mode sends each address as two halves on consecutive rising edges.
// - Refresh needs bank only, no second phase; may repeat every cycle.
// - Full address rebuilt from ball maps per data width and burst length.
// - Termination covers data and data mask; mask termination always on.
// - Data termination off while driving reads, back on after last beat.
// - Deselect starts nothing; accepted operations run to completion.
// - Read decoded when chip select low, write enable and refresh high.
// - Read data appears after read latency, edge aligned to strobe clock.
// - Read valid rises half a clock before the first data beat.
// - Read valid falls together with the final data beat.
// - Data lines released after a burst when nothing further follows.
// - Back-to-back reads give seamless data; strobe clock keeps toggling.
// - Write latency is read latency plus one.
// - Multiplexed mode adds one cycle to read and write latency.
// - Control lines decode to deselect, mode set, read, write, refresh; no combination decodes as illegal.
module lldr_core #(
  parameter int DW         = 36,
  parameter int AW         = 21,
  parameter int PIPE_DEPTH = 8,
  parameter int CAL_CYCLES = `LLDR_CAL_CYCLES
) (
  input  wire logic          pclk,
  input  wire logic          presetn,
  input  wire logic [11:0]   paddr,
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [31:0]   pwdata,
  output logic               pready,
  output logic [31:0]        prdata,
  output logic               pslverr,
  input  wire logic          ck,
  input  wire logic          cs_n,
  input  wire logic          we_n,
  input  wire logic          refresh_n,
  input  wire logic [2:0]    bank,
  input  wire logic [AW-1:0] address,
  input  wire logic [5:0]    impedance_ball_sense,
  output logic [DW-1:0]      dq_out,
  output logic               dq_oe,
  output logic               read_valid,
  output logic               read_strobe_clock,
  output logic               read_strobe_clock_n,
  output logic               dq_term_en,
  output logic               data_mask_term_en,
  output logic               imp_external,
  output logic [5:0]         imp_code,
  output logic               cal_update
);
  import lldr_pkg::*;

  localparam int SW = 1 + 3 + 3 + AW + 6;
  localparam int EW = 3 + AW;

  // ----------------------------------------------------------------------
  // pin synchronisers and input clock edge detection
  // ----------------------------------------------------------------------
  logic [SW-1:0] sync_a;
  logic [SW-1:0] sync_b;
  logic          ck_d;
  logic          ck_s;
  logic          ck_rise;
  logic          ck_fall;
  logic          s_cs_n;
  logic          s_we_n;
  logic          s_ref_n;
  logic [2:0]    s_bank;
  logic [AW-1:0] s_addr;
  logic [5:0]    s_ball;

  // all pins share one delay, so set-up to the clock edge is kept
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync_a <= '0;
      sync_b <= '0;
      ck_d   <= 1'b0;
    end else begin
      sync_a <= {ck, cs_n, we_n, refresh_n, bank, address, impedance_ball_sense};
      sync_b <= sync_a;
      ck_d   <= ck_s;
    end
  end

  assign {ck_s, s_cs_n, s_we_n, s_ref_n, s_bank, s_addr, s_ball} = sync_b;
  assign ck_rise = ck_s & ~ck_d;
  assign ck_fall = ~ck_s & ck_d;

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  lldr_cmd_type cmd;

  always_comb begin
    if (s_cs_n)                  cmd = LLDR_CMD_NONE;
    else if (!s_we_n && !s_ref_n) cmd = LLDR_CMD_MODE;
    else if (s_we_n && s_ref_n)   cmd = LLDR_CMD_READ;
    else if (!s_we_n)             cmd = LLDR_CMD_WRITE;
    else                          cmd = LLDR_CMD_REFR;
  end

  // ----------------------------------------------------------------------
  // mode register and DLL lock tracking
  // ----------------------------------------------------------------------
  lldr_mode_type mode, next_mode;
  lldr_dll_type  dll, next_dll;
  logic [10:0]   lock_cnt, next_lock_cnt;
  logic          illegal, next_illegal;
  logic          phase_busy;

  always_comb begin
    next_mode     = mode;
    next_dll      = dll;
    next_lock_cnt = lock_cnt;
    next_illegal  = illegal;
    if (ck_rise && !phase_busy && cmd == LLDR_CMD_MODE) begin
      next_mode.cfg = s_addr[`LLDR_MODE_CFG_LSB +: 3];
      next_mode.bl  = s_addr[`LLDR_MODE_BL_LSB +: 2];
      next_mode.mux = s_addr[`LLDR_MODE_MUX_BIT];
      next_mode.dll = s_addr[`LLDR_MODE_DLL_BIT];
      next_mode.imp = s_addr[`LLDR_MODE_IMP_BIT];
      next_mode.odt = s_addr[`LLDR_MODE_ODT_BIT];
      // low turns the DLL off, a fresh high restarts the lock count
      if (!s_addr[`LLDR_MODE_DLL_BIT]) begin
        next_dll = LLDR_DLL_OFF;
      end else if (dll == LLDR_DLL_OFF) begin
        next_dll      = LLDR_DLL_LOCKING;
        next_lock_cnt = 11'h0;
      end
    end else if (ck_rise && dll == LLDR_DLL_LOCKING) begin
      next_lock_cnt = lock_cnt + 11'h1;
      if (next_lock_cnt == `LLDR_DLL_LOCK_CK) next_dll = LLDR_DLL_LOCKED;
    end
    // set-only flag for LLDR_CMD_ILL, a command that no control combination decodes to
    if (ck_rise && !phase_busy && cmd == LLDR_CMD_ILL) next_illegal = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode     <= '0;
      dll      <= LLDR_DLL_OFF;
      lock_cnt <= 11'h0;
      illegal  <= 1'b0;
    end else begin
      mode     <= next_mode;
      dll      <= next_dll;
      lock_cnt <= next_lock_cnt;
      illegal  <= next_illegal;
    end
  end

  // ----------------------------------------------------------------------
  // latency and burst length from the programmed mode
  // ----------------------------------------------------------------------
  logic [3:0] rl_base;
  logic [3:0] rl_eff;
  logic [3:0] wl_eff;
  logic [3:0] beats;
  logic [2:0] tap;

  always_comb begin
    case (mode.cfg)
      3'h2:    rl_base = 4'h6;
      3'h3:    rl_base = 4'h8;
      3'h4:    rl_base = 4'h3;
      3'h5:    rl_base = 4'h5;
      default: rl_base = 4'h4;
    endcase
    case (mode.bl)
      2'h1:    beats = 4'h4;
      2'h2:    beats = 4'h8;
      default: beats = 4'h2;
    endcase
    rl_eff = rl_base + {3'h0, mode.mux};
    wl_eff = rl_eff + 4'h1;
    // multiplexed reads enter the pipe one edge later, same tap
    tap    = 3'(rl_base - 4'h1);
  end

  // ----------------------------------------------------------------------
  // address phases and rebuild of the multiplexed address
  // ----------------------------------------------------------------------
  lldr_phase_type phase, next_phase;
  logic [10:0]    first_phase, next_first_phase;
  logic [2:0]     held_bank, next_held_bank;
  logic           held_read, next_held_read;
  logic           enq;
  logic [EW-1:0]  enq_entry;
  logic [AW-1:0]  full;
  lldr_width_type width;

  assign phase_busy = (phase == LLDR_PH_SECOND);

  // ball order A0 A3 A4 A5 A8 A9 A10 A13 A14 A17 A18
  function automatic logic [AW-1:0] lldr_rebuild(input logic [10:0] fp,
                                                 input logic [10:0] sp,
                                                 input lldr_width_type w,
                                                 input logic [1:0] bl);
    logic [AW-1:0] a;
    a      = '0;
    a[0]   = fp[0];
    a[3]   = fp[1];
    a[4]   = fp[2];
    a[5]   = fp[3];
    a[8]   = fp[4];
    a[9]   = fp[5];
    a[10]  = fp[6];
    a[13]  = fp[7];
    a[14]  = fp[8];
    a[17]  = fp[9] & ~(w == LLDR_W36 && bl == 2'h2);
    a[18]  = fp[10] & ~((w == LLDR_W36 && bl != 2'h0) || (w == LLDR_W18 && bl == 2'h2));
    a[1]   = sp[1];
    a[2]   = sp[2];
    a[6]   = sp[4];
    a[7]   = sp[5];
    a[11]  = sp[7];
    a[12]  = sp[8];
    a[16]  = sp[9];
    a[15]  = sp[10];
    a[19]  = sp[6] & ((w == LLDR_W18 && bl == 2'h0) || (w == LLDR_W9 && bl != 2'h2));
    a[20]  = sp[0] & (w == LLDR_W9 && bl == 2'h0);
    return a;
  endfunction

  always_comb begin
    next_phase       = phase;
    next_first_phase = first_phase;
    next_held_bank   = held_bank;
    next_held_read   = held_read;
    enq              = 1'b0;
    full             = s_addr;
    enq_entry        = {s_bank, s_addr};
    if (ck_rise) begin
      if (phase == LLDR_PH_SECOND) begin
        // the edge after the command carries only the second half
        full       = lldr_rebuild(first_phase, s_addr[10:0], width, mode.bl);
        enq_entry  = {held_bank, full};
        enq        = held_read;
        next_phase = LLDR_PH_IDLE;
      end else if (mode.mux && (cmd == LLDR_CMD_READ || cmd == LLDR_CMD_WRITE)) begin
        next_first_phase = s_addr[10:0];
        next_held_bank   = s_bank;
        next_held_read   = (cmd == LLDR_CMD_READ);
        next_phase       = LLDR_PH_SECOND;
      end else if (cmd == LLDR_CMD_READ) begin
        enq = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase       <= LLDR_PH_IDLE;
      first_phase <= 11'h0;
      held_bank   <= 3'h0;
      held_read   <= 1'b0;
    end else begin
      phase       <= next_phase;
      first_phase <= next_first_phase;
      held_bank   <= next_held_bank;
      held_read   <= next_held_read;
    end
  end

  // ----------------------------------------------------------------------
  // read latency pipe, one slot per input clock
  // ----------------------------------------------------------------------
  logic [PIPE_DEPTH-1:0] pipe_v, next_pipe_v;
  logic [EW-1:0]         pipe_a [PIPE_DEPTH];
  logic [EW-1:0]         next_pipe_a [PIPE_DEPTH];

  // accepted reads keep moving whatever commands follow
  always_comb begin
    next_pipe_v = pipe_v;
    next_pipe_a = pipe_a;
    if (ck_rise) begin
      next_pipe_v = {pipe_v[PIPE_DEPTH-2:0], enq};
      next_pipe_a[0] = enq_entry;
      for (int i = 1; i < PIPE_DEPTH; i++) begin
        next_pipe_a[i] = pipe_a[i-1];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pipe_v <= '0;
      for (int i = 0; i < PIPE_DEPTH; i++) begin
        pipe_a[i] <= '0;
      end
    end else begin
      pipe_v <= next_pipe_v;
      pipe_a <= next_pipe_a;
    end
  end

  // ----------------------------------------------------------------------
  // burst engine
  // ----------------------------------------------------------------------
  lldr_beat_if #(.DW(DW)) beat_bus ();

  assign beat_bus.rise  = ck_rise;
  assign beat_bus.fall  = ck_fall;
  assign beat_bus.start = pipe_v[tap];
  assign beat_bus.pre   = pipe_v[tap];
  assign beat_bus.beats = beats;
  assign beat_bus.base  = DW'(pipe_a[tap]);

  lldr_beat #(.DW(DW)) u_beat (
    .pclk    (pclk),
    .presetn (presetn),
    .bus     (beat_bus)
  );

  assign dq_out              = beat_bus.dq;
  assign dq_oe               = beat_bus.oe;
  assign read_valid          = beat_bus.valid;
  assign read_strobe_clock   = beat_bus.strobe;
  assign read_strobe_clock_n = ~beat_bus.strobe;
  assign dq_term_en          = mode.odt & ~beat_bus.oe;
  assign data_mask_term_en   = 1'b1;

  // ----------------------------------------------------------------------
  // impedance calibration
  // ----------------------------------------------------------------------
  logic [$clog2(CAL_CYCLES)-1:0] cal_cnt, next_cal_cnt;
  logic [5:0]                    code, next_code;
  logic                          upd, next_upd;

  // the code moves only at the tick, never touching read timing
  always_comb begin
    next_upd     = 1'b0;
    next_code    = code;
    next_cal_cnt = cal_cnt + 1'b1;
    if (cal_cnt == ($clog2(CAL_CYCLES))'(CAL_CYCLES - 1)) begin
      next_cal_cnt = '0;
      next_upd     = 1'b1;
      next_code    = mode.imp ? s_ball : `LLDR_IMP_NOMINAL;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_cnt <= '0;
      code    <= `LLDR_IMP_NOMINAL;
      upd     <= 1'b0;
    end else begin
      cal_cnt <= next_cal_cnt;
      code    <= next_code;
      upd     <= next_upd;
    end
  end

  assign imp_external = mode.imp;
  assign imp_code     = code;
  assign cal_update   = upd;

  // ----------------------------------------------------------------------
  // APB slave: zero wait states, read data captured in setup
  // ----------------------------------------------------------------------
  logic [1:0]  cfg_reg, next_cfg_reg;
  logic [31:0] rdata, next_rdata;
  logic        hit;

  assign width = lldr_width_type'(cfg_reg);

  always_comb begin
    next_cfg_reg = cfg_reg;
    next_rdata   = rdata;
    hit          = 1'b1;
    if (paddr == `LLDR_REG_CFG) begin
      if (psel && !penable) next_rdata = {30'h0, cfg_reg};
      if (psel && penable && pwrite) next_cfg_reg = pwdata[1:0];
    end else if (paddr == `LLDR_REG_MODE) begin
      if (psel && !penable) next_rdata = {22'h0, mode.odt, mode.imp, mode.dll,
                                          1'b0, mode.mux, mode.bl, mode.cfg};
    end else if (paddr == `LLDR_REG_STAT) begin
      if (psel && !penable) begin
        next_rdata = 32'h0;
        next_rdata[1:0] = dll;
        next_rdata[`LLDR_STAT_RL_LSB +: 4]  = rl_eff;
        next_rdata[`LLDR_STAT_WL_LSB +: 4]  = wl_eff;
        next_rdata[`LLDR_STAT_IMP_LSB +: 6] = code;
        next_rdata[`LLDR_STAT_ILL_BIT]      = illegal;
      end
    end else begin
      hit = 1'b0;
      if (psel && !penable) next_rdata = 32'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_reg <= `LLDR_CFG_RST;
      rdata   <= 32'h0;
    end else begin
      cfg_reg <= next_cfg_reg;
      rdata   <= next_rdata;
    end
  end

  assign pready  = 1'b1;
  assign prdata  = rdata;
  assign pslverr = psel & penable & ~hit;
endmodule

// ---- tb/lldr_core_sva.sv ----
`timescale 1ns/10ps
module lldr_core_sva #(
  parameter int CAL_CYCLES = 16
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [11:0] paddr,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        dq_oe,
  input wire logic        dq_term_en,
  input wire logic        data_mask_term_en,
  input wire logic        read_valid,
  input wire logic        read_strobe_clock,
  input wire logic        read_strobe_clock_n,
  input wire logic        cal_update
);
  logic [15:0] gap;
  logic        seen;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since the last calibration tick; the first tick only arms the check
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap  <= 16'h0;
      seen <= 1'b0;
    end else begin
      gap  <= cal_update ? 16'h0 : gap + 16'h1;
      seen <= seen | cal_update;
    end
  end
  apb_ready_a: assert property (pready) else $error("pready low");
  apb_err_a: assert property (pslverr == (psel && penable &&
    !(paddr inside {12'h000, 12'h004, 12'h008}))) else $error("pslverr wrong");
  mask_term_a: assert property (data_mask_term_en) else $error("mask term off");
  term_off_a: assert property (dq_oe |-> !dq_term_en) else $error("term on");
  strobe_pair_a: assert property (read_strobe_clock_n == !read_strobe_clock)
    else $error("strobe pair");
  strobe_runs_a: assert property ($rose(read_strobe_clock) |-> ##[3:5]
    $fell(read_strobe_clock)) else $error("strobe stopped");
  valid_lead_a: assert property ($rose(read_valid) |-> ##[3:5] dq_oe)
    else $error("valid lead");
  valid_end_a: assert property ($fell(read_valid) |-> dq_oe) else $error("valid end");
  bus_release_a: assert property ($fell(dq_oe) |-> !read_valid) else $error("release");
  cal_period_a: assert property (cal_update && seen |-> gap == CAL_CYCLES - 1)
    else $error("cal period");
  cover property ($rose(dq_oe));
  cover property (pslverr);
  cover property (cal_update && seen);
endmodule
bind lldr_core lldr_core_sva #(.CAL_CYCLES(CAL_CYCLES)) i_lldr_core_sva (
  .pclk, .presetn, .paddr, .psel, .penable, .pready, .pslverr, .dq_oe, .dq_term_en,
  .data_mask_term_en, .read_valid, .read_strobe_clock, .read_strobe_clock_n, .cal_update);

// ---- tb/lldr_ctl_model.sv ----
`timescale 1ns/10ps
module lldr_ctl_model (
  output logic        ck,
  output logic        cs_n,
  output logic        we_n,
  output logic        refresh_n,
  output logic [2:0]  bank,
  output logic [20:0] address
);
  initial begin
    {ck, cs_n, we_n, refresh_n, bank, address} = {4'h7, 24'h0};
  end
  // free running input clock; commands change on its falling edge
  always #400 ck = ~ck;
  // code is {we_n, refresh_n}: 00 mode set, 11 read, 10 refresh, address with it
  task automatic issue(input logic [1:0] c, input logic [2:0] b, input logic [20:0] a);
    @(negedge ck);
    cs_n <= 1'b0;
    {we_n, refresh_n} <= c;
    bank <= b;
    address <= a;
  endtask
  // deselect; bank and address keep changing so a stale value is never trusted
  task automatic idle(input int n);
    repeat (n) begin
      @(negedge ck);
      cs_n <= 1'b1;
      bank <= ~bank;
      address <= ~address;
    end
  endtask
endmodule

// ---- tb/lldr_core_tb.sv ----
`timescale 1ns/10ps
module lldr_core_tb;
  logic pclk, presetn, psel, penable, pwrite, er;
  logic pready, pslverr, dq_oe, read_valid, rsc, rsc_n, dq_term_en, dm_term, imp_ext, cal;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [35:0] dq_out;
  logic [5:0]  imp_code, sense;
  logic ck, cs_n, we_n, refresh_n;
  logic [2:0]  bank;
  logic [20:0] address;
  int miscompares = 0, check_count = 0;
  time t0;
  initial pclk = 1'b0;
  always #50 pclk = ~pclk;
  lldr_core #(.CAL_CYCLES(16)) i_lldr_core (.pclk, .presetn, .paddr, .psel, .penable,
    .pwrite, .pwdata, .pready, .prdata, .pslverr, .ck, .cs_n, .we_n, .refresh_n, .bank,
    .address, .impedance_ball_sense(sense), .dq_out, .dq_oe, .read_valid,
    .read_strobe_clock(rsc), .read_strobe_clock_n(rsc_n), .dq_term_en,
    .data_mask_term_en(dm_term), .imp_external(imp_ext), .imp_code, .cal_update(cal));
  lldr_ctl_model i_lldr_ctl_model (.ck, .cs_n, .we_n, .refresh_n, .bank, .address);
  task automatic test_done();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic chk(input logic [35:0] g, input logic [35:0] e);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for pready at the access edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    {rd, er} = {prdata, pslverr};
    {psel, penable} <= 2'b00;
  endtask
  // beats every half ck; more means another burst follows seamlessly
  task automatic burst(input logic [35:0] base, input int n, input int rl, input bit more);
    int w = 0;
    while (dq_oe !== 1'b1 && w < 400) begin
      @(posedge pclk);
      #1 w++;
    end
    if (rl > 0) chk(36'(($time - t0) / 800), 36'(rl));
    for (int k = 0; k < n; k++) begin
      chk({dq_oe, dq_term_en, read_valid}, {2'b10, k != n - 1 || more});
      chk(dq_out, base + 36'(k));
      repeat (4) @(posedge pclk);
      #1;
    end
    if (!more) chk(dq_oe, 1'b0);
  endtask
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, sense} <= {4'h0, 12'h0, 32'h0, 6'h15};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    chk(imp_code, 6'h20);
    apb(0, 12'h008, 0);
    chk(rd[1:0], 2'h0);
    apb(1, 12'h000, 32'hffffffff);
    apb(0, 12'h000, 0);
    chk(rd, 32'h3);
    apb(1, 12'h000, 0);
    apb(0, 12'h00c, 0);
    chk({er, rd}, 33'h100000000);
    i_lldr_ctl_model.issue(2'b11, 3'h5, 21'h12345);
    t0 = $time + 400;
    i_lldr_ctl_model.idle(1);
    burst({15'h5, 21'h12345}, 2, 4, 0);
    i_lldr_ctl_model.issue(2'b00, 3'h0, 21'h28a);
    i_lldr_ctl_model.idle(4);
    apb(0, 12'h004, 0);
    chk(rd, 32'h28a);
    apb(0, 12'h008, 0);
    chk(rd[1:0], 2'h1);
    i_lldr_ctl_model.idle(1024);
    apb(0, 12'h008, 0);
    chk({rd[11:4], rd[1:0]}, 10'h1db);
    chk(dq_term_en, 1'b1);
    i_lldr_ctl_model.issue(2'b10, 3'h1, 21'h0);
    i_lldr_ctl_model.issue(2'b10, 3'h2, 21'h0);
    i_lldr_ctl_model.issue(2'b11, 3'h1, 21'h100);
    t0 = $time + 400;
    i_lldr_ctl_model.idle(1);
    i_lldr_ctl_model.issue(2'b11, 3'h2, 21'h200);
    i_lldr_ctl_model.idle(1);
    burst({15'h1, 21'h100}, 4, 6, 1);
    burst({15'h2, 21'h200}, 4, 0, 0);
    i_lldr_ctl_model.issue(2'b00, 3'h0, 21'h0);
    i_lldr_ctl_model.idle(8);
    apb(0, 12'h008, 0);
    chk(rd[1:0], 2'h0);
    i_lldr_ctl_model.issue(2'b00, 3'h0, 21'h1a0);
    i_lldr_ctl_model.idle(1024);
    chk({imp_ext, imp_code}, 7'h55);
    // a new resistor reading must reach the code at a later tick
    @(posedge pclk);
    sense <= 6'h2a;
    i_lldr_ctl_model.idle(4);
    chk({imp_ext, imp_code}, 7'h6a);
    // second half carries a read code that must be taken as address only
    i_lldr_ctl_model.issue(2'b11, 3'h3, 21'h0);
    t0 = $time + 400;
    i_lldr_ctl_model.issue(2'b11, 3'h4, 21'h7ff);
    i_lldr_ctl_model.idle(1);
    burst({15'h3, 21'h198c6}, 2, 5, 0);
    // narrowest width: two extra bits come from the second half
    apb(1, 12'h000, 32'h2);
    i_lldr_ctl_model.issue(2'b11, 3'h6, 21'h0);
    t0 = $time + 400;
    i_lldr_ctl_model.issue(2'b11, 3'h4, 21'h7ff);
    i_lldr_ctl_model.idle(1);
    burst({15'h6, 21'h1998c6}, 2, 5, 0);
    test_done();
  end
  // watchdog: two lock waits dominate the run
  initial begin
    #3500000;
    miscompares++;
    test_done();
  end
endmodule
